// file: hw/lsc_display_ram.sv
`include "lsc_params.svh"

module lsc_display_ram
    import lsc_pkg::*;
(
    // clock
    input  wire logic        clk_sys_i,
    // write port
    input  wire logic        we_i,
    input  wire logic [4:0]  idx_i,
    input  wire logic [7:0]  wdata_i,
    // read side
    output logic [7:0]       rdata_o,
    output logic [3:0][47:0] banks_o
);

    logic [`LSC_RAM_BYTES-1:0][7:0] mem; // storage, never reset

    // one write slot per byte, no reset so contents start arbitrary
    for (genvar i = 0; i < `LSC_RAM_BYTES; i++) begin : g_byte
        always_ff @(posedge clk_sys_i) begin
            if (we_i && (idx_i == 5'(i))) begin
                mem[i] <= wdata_i;
            end
        end
    end

    // banks of six bytes, common 1 first
    assign banks_o = mem;
    assign rdata_o = (idx_i < 5'(`LSC_RAM_BYTES)) ? mem[idx_i] : 8'h00;

endmodule : lsc_display_ram

// file: hw/lsc_lcd_segment_controller.sv
// Functional notes
// - oscillator divided by selected factor, 000 off
// - oscillator failure grounds all segment, common lines
// - ratio field selects one to four commons
// - base frequency from reference by selected factor
// - frame rate is base over active commons
// - bias divider off while driver off
// - set ram bit turns element on
// - display ram is not cleared by reset
// - unused common bytes are ordinary storage
// - ram at e0..f7, six bytes per common
// - segment n at byte (n-1)/8, bit (n-1)%8
// - low reference detection may switch driver off
// - stop mode switches off and grounds lines
// - mode register holds ratio, oscillator, base fields
`include "lsc_params.svh"

module lsc_lcd_segment_controller
    import lsc_pkg::*;
(
    // clock and reset
    input  wire logic          clk_sys_i,
    input  wire logic          nrst_i,
    // core data space access
    input  wire lsc_cpu_req_t  cpu_req_i,
    output logic [7:0]         cpu_rdata_o,
    output logic               cpu_hit_o,
    // system status
    input  wire logic          osc_fail_i,
    input  wire logic          stop_mode_i,
    input  wire logic          low_freq_detect_i,
    // panel side
    output lsc_panel_t         panel_o,
    output logic               lines_grounded_o,
    output logic               driver_on_o,
    output lsc_mode_t          display_mode_control_o
);

    // overview of the datapath:
    // the core reaches two things through plain strobes, the
    // mode byte and a 24 byte display store (one 48 bit bank
    // per common). the mode byte picks the oscillator divider,
    // the base rate and how many commons take part.
    // while running, the commons are driven one at a time for
    // one base period each; the segment lines follow the bank
    // of the common that owns the current slot.
    // any forcing cause (oscillator fault, stop, low reference)
    // drops every line to zero within a few clocks, so the
    // glass never sees a steady offset.
    // leaving ground always passes through the off state, so a
    // fresh frame restarts from common one with phase zero.
    // the store itself is never cleared; software owns it.

    // reset synchroniser
    logic rst_meta_n_r;  // first stage
    logic rst_n_r;       // released reset used by all logic

    // controller state
    lsc_top_state_t st_r;   // registered state
    lsc_top_state_t st_nxt; // next state

    // ram and divider connections
    logic            ram_we;      // write into display ram
    logic [4:0]      ram_idx;     // byte index inside ram
    logic [7:0]      ram_rdata;   // byte read from ram
    logic [3:0][47:0] ram_banks;  // all four banks
    logic            base_tick;   // base frequency pulse
    logic            in_ram;      // address inside ram window
    logic            fault;       // any condition forcing ground
    logic            cfg_ok;      // mode register allows display
    logic [1:0]      last_slot;   // highest active common index
    logic [7:0]      addr_off;    // address minus ram base

    // reset release through two flops, assert at once
    // hazard: a raw release close to an edge could let some
    // flops leave reset a cycle before others; the copy below
    // releases on a clean edge for every process in the block
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_meta_n_r <= 1'b0;
            rst_n_r      <= 1'b0;
        end else begin
            rst_meta_n_r <= 1'b1;
            rst_n_r      <= rst_meta_n_r;
        end
    end

    // address decode for the display ram window
    // the offset is taken modulo 256 and only its low five bits
    // index the store; outside the window the index is junk but
    // neither the write enable nor the read mux then uses it
    assign addr_off = cpu_req_i.addr - `LSC_RAM_FIRST;
    assign in_ram   = (cpu_req_i.addr >= `LSC_RAM_FIRST) && (cpu_req_i.addr <= `LSC_RAM_LAST);
    assign ram_idx  = addr_off[4:0];
    assign ram_we   = cpu_req_i.wr && in_ram;

    // display ram, no reset
    // storage keeps its bytes across a reset on purpose; bytes
    // of commons left unused stay plain read/write storage
    lsc_display_ram u_ram (
        .clk_sys_i (clk_sys_i),
        .we_i      (ram_we),
        .idx_i     (ram_idx),
        .wdata_i   (cpu_req_i.wdata),
        .rdata_o   (ram_rdata),
        .banks_o   (ram_banks)
    );

    // reference and base frequency generation, runs only while displaying
    // holding the counters at zero when not running makes the
    // first slot after start a full base period long
    lsc_ref_divider u_div (
        .clk_sys_i   (clk_sys_i),
        .rst_n_i     (rst_n_r),
        .enable_i    (st_r.state == LSC_ST_RUN),
        .osc_sel_i   (st_r.mode.osc_divider_select),
        .base_sel_i  (st_r.mode.base_frame_rate_select),
        .base_tick_o (base_tick)
    );

    // forced ground on failure, stop or low reference
    // stop and low reference come from logic on this clock and
    // are used as they are; only the failure pin is synchronised
    // limitation: a fault shorter than one cycle may be missed
    assign fault = st_r.fail_sync || stop_mode_i || low_freq_detect_i;

    // valid oscillator and base codes only
    // undefined oscillator codes and the reserved base code keep
    // the display off rather than running at a strange rate
    always_comb begin
        case (st_r.mode.osc_divider_select)
            `LSC_OSC_DIV32,
            `LSC_OSC_DIV64,
            `LSC_OSC_DIV128,
            `LSC_OSC_DIV256: cfg_ok = (st_r.mode.base_frame_rate_select != `LSC_BASE_RESERVED);
            default:         cfg_ok = 1'b0; // off code or undefined codes
        endcase
    end

    // number of active commons minus one
    // note the odd code order: 00 selects all four commons,
    // the other codes give as many commons as their value
    always_comb begin
        case (st_r.mode.mux_ratio_sel)
            `LSC_RATIO_4: last_slot = 2'h3;
            `LSC_RATIO_1: last_slot = 2'h0;
            `LSC_RATIO_2: last_slot = 2'h1;
            `LSC_RATIO_3: last_slot = 2'h2;
            default:      last_slot = 2'h0;
        endcase
    end

    // next state: sync, register access, sequencing, drive
    always_comb begin
        st_nxt = st_r;

        // oscillator failure pin passes two flops
        // only fail_sync is read by logic; fail_meta may be unsettled
        st_nxt.fail_meta = osc_fail_i;
        st_nxt.fail_sync = st_r.fail_meta;

        // mode control register write
        // a new mode takes effect on the next edge; a ratio cut
        // mid-frame is handled by the wrap test in the run state
        if (cpu_req_i.wr && (cpu_req_i.addr == `LSC_MODE_ADDR)) begin
            st_nxt.mode = lsc_mode_t'(cpu_req_i.wdata);
        end

        // read data, zero on unmapped addresses
        // answer stands one cycle and falls back to zero, so a
        // stale byte never looks like a fresh answer
        st_nxt.rdata = 8'h00;
        st_nxt.hit   = 1'b0;
        if (cpu_req_i.rd) begin
            if (cpu_req_i.addr == `LSC_MODE_ADDR) begin
                st_nxt.rdata = st_r.mode;
                st_nxt.hit   = 1'b1;
            end else if (in_ram) begin
                st_nxt.rdata = ram_rdata;
                st_nxt.hit   = 1'b1;
            end
        end

        // controller sequencing
        case (st_r.state)
            LSC_ST_OFF: begin
                // idle until configured
                // fault has priority, so a bad start never drives
                st_nxt.slot     = 2'h0;
                st_nxt.panel.polarity = 1'b0;
                if (fault) begin
                    st_nxt.state = LSC_ST_GROUND;
                end else if (cfg_ok) begin
                    st_nxt.state = LSC_ST_RUN;
                end
            end
            LSC_ST_RUN: begin
                if (fault) begin
                    st_nxt.state = LSC_ST_GROUND;
                end else if (!cfg_ok) begin
                    st_nxt.state = LSC_ST_OFF;
                end else if (base_tick) begin
                    // one slot per base period, frame ends after last common
                    // the >= test also wraps a slot left beyond a
                    // smaller ratio written while running
                    // the phase bit flips once per frame, at the wrap
                    if (st_r.slot >= last_slot) begin
                        st_nxt.slot           = 2'h0;
                        st_nxt.panel.polarity = ~st_r.panel.polarity;
                    end else begin
                        st_nxt.slot = st_r.slot + 2'h1;
                    end
                end
            end
            LSC_ST_GROUND: begin
                // hold ground until every forcing cause is gone
                // exit goes to off, which rechecks the mode byte
                st_nxt.slot           = 2'h0;
                st_nxt.panel.polarity = 1'b0;
                if (!fault) begin
                    st_nxt.state = LSC_ST_OFF;
                end
            end
            default: begin
                st_nxt.state = LSC_ST_OFF;
            end
        endcase

        // panel drive from the next slot, all low unless running
        // drive is built from the next state so that lines fall
        // on the same edge as the state leaves run, not one later
        // segments follow the store live: a write shows one edge after the byte lands
        if (st_nxt.state == LSC_ST_RUN) begin
            st_nxt.panel.backplane_lines     = 4'h1 << st_nxt.slot;
            st_nxt.panel.seg                 = ram_banks[st_nxt.slot][`LSC_BANK_BITS-1:`LSC_SEG_FIRST_BIT];
            st_nxt.panel.panel_supply_div_en = 1'b1;
        end else begin
            st_nxt.panel.backplane_lines     = 4'h0;
            st_nxt.panel.seg                 = '0;
            st_nxt.panel.polarity            = 1'b0;
            st_nxt.panel.panel_supply_div_en = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            st_r       <= '0;
            st_r.mode  <= lsc_mode_t'(`LSC_MODE_RESET);
            st_r.state <= LSC_ST_OFF;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from registers
    // grounded and driver flags are pure decodes of the state
    // register, so they agree with the panel drive every cycle
    assign cpu_rdata_o            = st_r.rdata;
    assign cpu_hit_o              = st_r.hit;
    assign panel_o                = st_r.panel;
    assign lines_grounded_o       = (st_r.state != LSC_ST_RUN);
    assign driver_on_o            = (st_r.state == LSC_ST_RUN);
    assign display_mode_control_o = st_r.mode;

    // limitations worth knowing:
    // - reads and writes to one byte in one cycle give the old
    //   byte; the new one is seen from the next cycle on
    // - the drive is logic levels only; the stepped bias
    //   voltages are made outside this block
    // - the phase bit only marks frames; turning it into an
    //   alternating drive is left to the output stage

endmodule : lsc_lcd_segment_controller

// file: hw/lsc_params.svh
`ifndef LSC_PARAMS_SVH
`define LSC_PARAMS_SVH

// data space addresses
`define LSC_MODE_ADDR      8'hdc
`define LSC_RAM_FIRST      8'he0
`define LSC_RAM_LAST       8'hf7
`define LSC_BANK_BYTES     6
`define LSC_BANK_BITS      48
`define LSC_RAM_BYTES      24
`define LSC_NUM_COMMONS    4
`define LSC_MODE_RESET     8'h00

// mode control field positions
`define LSC_RATIO_MSB      7
`define LSC_RATIO_LSB      6
`define LSC_OSC_MSB        5
`define LSC_OSC_LSB        3
`define LSC_BASE_MSB       2
`define LSC_BASE_LSB       0

// segment placement inside a bank
`define LSC_SEG_FIRST_BIT  3
`define LSC_SEG_COUNT      45

// ratio codes
`define LSC_RATIO_4        2'h0
`define LSC_RATIO_1        2'h1
`define LSC_RATIO_2        2'h2
`define LSC_RATIO_3        2'h3

// oscillator select codes and division factors
`define LSC_OSC_OFF        3'h0
`define LSC_OSC_DIV32      3'h3
`define LSC_OSC_DIV64      3'h4
`define LSC_OSC_DIV128     3'h5
`define LSC_OSC_DIV256     3'h6
`define LSC_OSC_F32        9'h020
`define LSC_OSC_F64        9'h040
`define LSC_OSC_F128       9'h080
`define LSC_OSC_F256       9'h100

// base frequency codes and reference division factors
`define LSC_BASE_RESERVED  3'h7
`define LSC_BASE_F0        10'h200
`define LSC_BASE_F1        10'h182
`define LSC_BASE_F2        10'h100
`define LSC_BASE_F3        10'h0c0
`define LSC_BASE_F4        10'h080
`define LSC_BASE_F5        10'h060
`define LSC_BASE_F6        10'h040

`endif

// file: hw/lsc_pkg.sv
`include "lsc_params.svh"

package lsc_pkg;

    // mode control register layout, msb first
    typedef struct packed {
        logic [1:0] mux_ratio_sel;          // ratio field
        logic [2:0] osc_divider_select;     // oscillator select field
        logic [2:0] base_frame_rate_select; // base frequency field
    } lsc_mode_t;

    // one data space access from the core
    typedef struct packed {
        logic       wr;    // write strobe
        logic       rd;    // read strobe
        logic [7:0] addr;  // data space address
        logic [7:0] wdata; // write data
    } lsc_cpu_req_t;

    // panel drive levels
    typedef struct packed {
        logic [3:0]  backplane_lines;      // one-hot active common
        logic [44:0] seg;                  // segment on flags, s4 in bit 0
        logic        polarity;             // frame inversion phase
        logic        panel_supply_div_en;  // bias divider enable
    } lsc_panel_t;

    // controller state
    typedef enum logic [1:0] {
        LSC_ST_OFF    = 2'b00,
        LSC_ST_RUN    = 2'b01,
        LSC_ST_GROUND = 2'b10
    } lsc_state_t;

    // divider state
    typedef struct packed {
        logic [8:0] pre_cnt;
        logic [9:0] base_cnt;
        logic       tick;
    } lsc_div_state_t;

    // top level state
    typedef struct packed {
        logic       fail_meta;
        logic       fail_sync;
        lsc_mode_t  mode;
        lsc_state_t state;
        logic [1:0] slot;
        lsc_panel_t panel;
        logic [7:0] rdata;
        logic       hit;
    } lsc_top_state_t;

endpackage : lsc_pkg

// file: hw/lsc_ref_divider.sv
`include "lsc_params.svh"

module lsc_ref_divider
    import lsc_pkg::*;
(
    // clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       rst_n_i,
    // configuration
    input  wire logic       enable_i,
    input  wire logic [2:0] osc_sel_i,
    input  wire logic [2:0] base_sel_i,
    // base frequency pulse
    output logic            base_tick_o
);

    lsc_div_state_t st_r;  // registered state
    lsc_div_state_t st_nxt; // next state

    // oscillator code to division factor
    function automatic logic [8:0] osc_factor(input logic [2:0] code);
        case (code)
            `LSC_OSC_DIV32:  osc_factor = `LSC_OSC_F32;
            `LSC_OSC_DIV64:  osc_factor = `LSC_OSC_F64;
            `LSC_OSC_DIV128: osc_factor = `LSC_OSC_F128;
            `LSC_OSC_DIV256: osc_factor = `LSC_OSC_F256;
            default:         osc_factor = `LSC_OSC_F256;
        endcase
    endfunction : osc_factor

    // base code to reference division factor
    function automatic logic [9:0] base_factor(input logic [2:0] code);
        case (code)
            3'h0:    base_factor = `LSC_BASE_F0;
            3'h1:    base_factor = `LSC_BASE_F1;
            3'h2:    base_factor = `LSC_BASE_F2;
            3'h3:    base_factor = `LSC_BASE_F3;
            3'h4:    base_factor = `LSC_BASE_F4;
            3'h5:    base_factor = `LSC_BASE_F5;
            3'h6:    base_factor = `LSC_BASE_F6;
            default: base_factor = `LSC_BASE_F0;
        endcase
    endfunction : base_factor

    // two cascaded counters: oscillator to reference, reference to base
    always_comb begin
        st_nxt      = st_r;
        st_nxt.tick = 1'b0;
        if (!enable_i) begin
            st_nxt.pre_cnt  = 9'h000;
            st_nxt.base_cnt = 10'h000;
        end else if (st_r.pre_cnt >= osc_factor(osc_sel_i) - 9'h001) begin
            st_nxt.pre_cnt = 9'h000;
            if (st_r.base_cnt >= base_factor(base_sel_i) - 10'h001) begin
                st_nxt.base_cnt = 10'h000;
                st_nxt.tick     = 1'b1;
            end else begin
                st_nxt.base_cnt = st_r.base_cnt + 10'h001;
            end
        end else begin
            st_nxt.pre_cnt = st_r.pre_cnt + 9'h001;
        end
    end

    // state register
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign base_tick_o = st_r.tick;

endmodule : lsc_ref_divider

// file: tb/lsc_lcd_segment_controller_chk.sv
module lsc_lcd_segment_controller_chk
    import lsc_pkg::*;
(
    // clock and reset
    input wire logic         clk_sys_i,
    input wire logic         nrst_i,
    // core access
    input wire lsc_cpu_req_t cpu_req_i,
    input wire logic [7:0]   cpu_rdata_o,
    input wire logic         cpu_hit_o,
    // status and panel
    input wire logic         osc_fail_i,
    input wire logic         stop_mode_i,
    input wire logic         low_freq_detect_i,
    input wire lsc_panel_t   panel_o,
    input wire logic         lines_grounded_o,
    input wire logic         driver_on_o,
    input wire lsc_mode_t    display_mode_control_o
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [3:0] prev_com_r; // common one cycle ago

    // remember the last common for the order check
    always_ff @(posedge clk_sys_i) prev_com_r <= panel_o.backplane_lines;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);

    a_fail_grounds: assert property (
        osc_fail_i [*5] |-> panel_o == '0) else $error("panel driven during oscillator fault");
    a_stop_grounds: assert property (
        stop_mode_i [*3] |-> panel_o == '0) else $error("panel driven in stop");
    a_lowf_off: assert property (
        low_freq_detect_i [*3] |-> !driver_on_o) else $error("driver on at low reference");
    a_div_off: assert property (
        !driver_on_o [*2] |-> !panel_o.panel_supply_div_en) else $error("bias divider on while off");
    a_com_onehot: assert property (
        $onehot0(panel_o.backplane_lines)) else $error("two commons active");
    a_com_order: assert property (
        display_mode_control_o.mux_ratio_sel == 2'h0 && prev_com_r != 4'h0
        && panel_o.backplane_lines != 4'h0 && panel_o.backplane_lines != prev_com_r
        |-> panel_o.backplane_lines == {prev_com_r[2:0], prev_com_r[3]}) else $error("common order wrong");
    a_single_com: assert property (
        display_mode_control_o.mux_ratio_sel == 2'h1 && $past(display_mode_control_o.mux_ratio_sel) == 2'h1
        && $changed(panel_o.backplane_lines) |-> panel_o.backplane_lines inside {4'h0, 4'h1})
        else $error("extra common at 1/1");
    a_rd_mode: assert property (
        cpu_req_i.rd && cpu_req_i.addr == 8'hdc |=> cpu_hit_o && cpu_rdata_o == $past(display_mode_control_o))
        else $error("mode read wrong");
    a_wr_mode: assert property (
        cpu_req_i.wr && cpu_req_i.addr == 8'hdc |=> display_mode_control_o == $past(cpu_req_i.wdata))
        else $error("mode write lost");
    a_unmapped_rd: assert property (
        cpu_req_i.rd && !(cpu_req_i.addr == 8'hdc || cpu_req_i.addr inside {[8'he0:8'hf7]})
        |=> !cpu_hit_o && cpu_rdata_o == 8'h00) else $error("unmapped read answered");
endmodule : lsc_lcd_segment_controller_chk

bind lsc_lcd_segment_controller lsc_lcd_segment_controller_chk u_chk (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .cpu_req_i(cpu_req_i), .cpu_rdata_o(cpu_rdata_o),
    .cpu_hit_o(cpu_hit_o), .osc_fail_i(osc_fail_i), .stop_mode_i(stop_mode_i),
    .low_freq_detect_i(low_freq_detect_i), .panel_o(panel_o), .lines_grounded_o(lines_grounded_o),
    .driver_on_o(driver_on_o), .display_mode_control_o(display_mode_control_o));

// file: tb/lsc_panel_model.sv
module lsc_panel_model
    import lsc_pkg::*;
(
    // clock and measurement restart
    input  wire logic       clk_sys_i,
    input  wire logic       clr_i,
    // drive from the controller
    input  wire lsc_panel_t panel_i,
    // what the glass saw
    output logic [3:0]      seen_o,
    output int              slot_len_o,
    output int              frame_len_o
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [3:0] prev_r; // last common drive
    logic       pol_r;  // last inversion phase
    int         scnt;   // cycles in current slot
    int         fcnt;   // cycles in current frame

    // passive glass: measure slots and frames
    always_ff @(posedge clk_sys_i) begin
        prev_r <= panel_i.backplane_lines;
        pol_r  <= panel_i.polarity;
        if (clr_i) begin
            seen_o <= '0;
            scnt   <= 0;
            fcnt   <= 0;
        end else begin
            seen_o <= seen_o | panel_i.backplane_lines;
            scnt   <= (panel_i.backplane_lines != prev_r) ? 1 : scnt + 1;
            fcnt   <= (panel_i.polarity != pol_r) ? 1 : fcnt + 1;
            if (panel_i.backplane_lines != prev_r && prev_r != 0 && panel_i.backplane_lines != 0)
                slot_len_o <= scnt;
            if (panel_i.polarity != pol_r)
                frame_len_o <= fcnt;
        end
    end
endmodule : lsc_panel_model

// file: tb/test_lcd_segment_controller.sv
module test_lcd_segment_controller
    import lsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic         clk_sys_i = 1'b0;
    logic         nrst_i    = 1'b0;
    lsc_cpu_req_t req       = '0;
    logic         osc_fail  = 1'b0;
    logic         stop      = 1'b0;
    logic         lowf      = 1'b0;
    logic         clr       = 1'b1;   // restarts glass measurements
    logic [7:0]   rdata;
    logic         hit, grounded, drv_on;
    lsc_panel_t   panel;
    lsc_mode_t    mode;
    logic [3:0]   seen;
    int           slot_len, frame_len, err_total, n_checks;
    logic [7:0]   ram [24];           // bench copy of display ram
    // modes to run, oscillator divided by 32, 64 or 128
    logic [7:0]   cfg [8] = '{8'h1e, 8'h9e, 8'hde, 8'h5e, 8'h66, 8'h6e, 8'h5d, 8'h5c};

    lsc_lcd_segment_controller dut (
        .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .cpu_req_i(req), .cpu_rdata_o(rdata), .cpu_hit_o(hit),
        .osc_fail_i(osc_fail), .stop_mode_i(stop), .low_freq_detect_i(lowf), .panel_o(panel),
        .lines_grounded_o(grounded), .driver_on_o(drv_on), .display_mode_control_o(mode));
    lsc_panel_model u_panel (
        .clk_sys_i(clk_sys_i), .clr_i(clr), .panel_i(panel), .seen_o(seen),
        .slot_len_o(slot_len), .frame_len_o(frame_len));

    always #20 clk_sys_i = ~clk_sys_i;

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic results;
        $display("checks=%0d errors=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : results

    // one write strobe, dropped right after the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        req <= '{1'b1, 1'b0, a, d};
        @(posedge clk_sys_i);
        req <= '0;
    endtask : wr

    // read strobe, answer sampled after the next edge
    task automatic rd(input logic [7:0] a, output logic [8:0] hd);
        @(posedge clk_sys_i);
        req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk_sys_i);
        req <= '0;
        #1 hd = {hit, rdata};
    endtask : rd

    // clocks per common slot
    function automatic int div_f(input logic [2:0] o, input logic [2:0] b);
        int f [8] = '{512, 386, 256, 192, 128, 96, 64, 0};
        return (32 << (o - 3'h3)) * f[b];
    endfunction : div_f

    // segments s4..s48 of one common bank
    function automatic logic [44:0] exp_seg(input int c);
        logic [47:0] b;
        for (int k = 0; k < 6; k++) b[k*8 +: 8] = ram[6*c + k];
        return b[47:3];
    endfunction : exp_seg

    task automatic rd_all;
        logic [8:0] hd;
        for (int k = 0; k < 24; k++) begin
            rd(8'(k) + 8'he0, hd);
            check(hd, {1'b1, ram[k]});
        end
    endtask : rd_all

    // run one mode for two frames and judge the glass
    task automatic run_cfg(input lsc_mode_t md);
        int n, d;
        logic [3:0] last;
        logic chg;
        n = (md.mux_ratio_sel == 2'h0) ? 4 : int'(md.mux_ratio_sel);
        d = div_f(md.osc_divider_select, md.base_frame_rate_select);
        clr <= 1'b1;
        wr(8'hdc, 8'h00);
        wr(8'hdc, md);
        clr <= 1'b0;
        chg = 1'b0;
        last = 4'h0;
        repeat (2 * n * d + 60) begin
            @(posedge clk_sys_i);
            #1;
            if (chg) for (int c = 0; c < 4; c++) if (last[c]) check(panel.seg, exp_seg(c));
            chg = (panel.backplane_lines !== last);
            last = panel.backplane_lines;
        end
        check(seen, (4'h1 << n) - 4'h1);
        check(frame_len, n * d);
        if (n > 1) check(slot_len, d);
        check(panel.panel_supply_div_en, 1'b1);
    endtask : run_cfg

    initial begin
        #(90000 * 40);
        err_total++;
        results();
    end

    initial begin
        logic [7:0] v;
        logic [8:0] hd;
        void'($urandom(12));
        repeat (3) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        #1 check({panel, grounded, drv_on, mode}, {51'h0, 2'b10, 8'h00});
        repeat (4) begin
            v = 8'($urandom);
            wr(8'hdc, v);
            rd(8'hdc, hd);
            check(hd, {1'b1, v});
        end
        foreach (cfg[i]) begin
            rd(cfg[i] | 8'h08, hd);
            check(hd, 9'h000);
        end
        for (int k = 0; k < 24; k++) begin
            ram[k] = 8'($urandom);
            wr(8'(k) + 8'he0, ram[k]);
        end
        foreach (cfg[i]) run_cfg(cfg[i]);
        rd_all();
        for (int f = 0; f < 3; f++) begin
            @(posedge clk_sys_i);
            {lowf, stop, osc_fail} <= 3'b001 << f;
            repeat (8) @(posedge clk_sys_i);
            #1 check({panel, grounded, drv_on}, {51'h0, 2'b10});
            @(posedge clk_sys_i);
            {lowf, stop, osc_fail} <= 3'b000;
            repeat (8) @(posedge clk_sys_i);
            #1 check(drv_on, 1'b1);
        end
        wr(8'hdc, 8'h46);
        repeat (4) @(posedge clk_sys_i);
        #1 check({panel, drv_on}, 52'h0);
        wr(8'hdc, 8'h1f);
        repeat (4) @(posedge clk_sys_i);
        #1 check({grounded, drv_on}, 2'b10);
        @(posedge clk_sys_i);
        nrst_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        #1 check(mode, 8'h00);
        rd_all();
        results();
    end
endmodule : test_lcd_segment_controller
